// ===== pbsp_core.sv
// Pipelined burst memory port: bus decode, burst counter, write buffer, array, read pipe.
`timescale 1ns/100ps
module pbsp_core (
    // Clocking
    input  wire logic                          clock,
    input  wire logic                          reset,
    input  wire logic                          clk_en,
    // Synchronous bus
    input  wire pbsp_pkg::pbsp_bus_t           bus,
    // Asynchronous and static pins
    input  wire logic                          output_enable_n,
    input  wire logic                          burst_order_sel,
    input  wire logic                          sleep_pin,
    // Data pins, split
    output logic [pbsp_pkg::DATA_W-1:0]        data_out,
    output logic                               data_oe_n,
    // Status
    output logic                               write_stall,
    output logic                               asleep
);
    // Synchroniser on the asynchronous sleep pin; only the second and third stage are read.
    logic [2:0] sleep_sync_reg;
    logic       sleep_reg;
    // Synchroniser on the static order select.
    logic [2:0] order_sync_reg;
    logic       order_il_reg;

    logic [pbsp_pkg::ADDR_W-1:0] addr_reg;
    logic [pbsp_pkg::ADDR_W-1:0] addr_next;
    logic [1:0]                  start_reg;
    logic [1:0]                  beat_reg;
    logic [1:0]                  beat_next;
    logic                        active_reg;
    logic                        active_next;
    logic                        processor_addr_strobe_n_cycle_reg;
    logic                        read_pend_reg;
    logic                        read_valid_reg;
    logic [pbsp_pkg::DATA_W-1:0] rdata_reg;
    logic [pbsp_pkg::DATA_W-1:0] data_out_reg;
    logic                        oe_n_reg;
    logic                        stall_reg;
    logic [pbsp_pkg::DATA_W-1:0] mem_reg [pbsp_pkg::DEPTH];

    // Write buffer signals.
    logic                        wq_in_ready;
    logic                        wq_out_valid;
    pbsp_pkg::pbsp_wr_t          wq_in;
    pbsp_pkg::pbsp_wr_t          wq_out;

    function automatic logic [1:0] burst_bits(input logic il, input logic [1:0] start,
                                              input logic [1:0] beat);
        burst_bits = il ? (start ^ beat) : (start + beat); // R12 R13
    endfunction

    // Level in sleep stops the bus decode and burst state; the synchronisers, the write buffer drain and the output flops keep running.
    wire sleep_now   = sleep_reg;                                       // R14 R15
    wire live        = clk_en && !sleep_now;                            // R16

    wire processor_addr_strobe_n_eff    = !bus.processor_addr_strobe_n && !bus.master_select_n; // R2
    wire controller_addr_strobe_n_eff    = !bus.controller_addr_strobe_n && bus.processor_addr_strobe_n; // R24
    wire start_cycle = processor_addr_strobe_n_eff || controller_addr_strobe_n_eff;                            // R4
    wire selected    = !bus.master_select_n && bus.chip_select_hi
                       && !bus.chip_select_lo_n;                        // R1 R3
    wire deselect    = (processor_addr_strobe_n_eff || !bus.controller_addr_strobe_n) && !selected; // R4 R26
    wire load        = start_cycle && selected;                         // R1
    // A processor strobe blocked by the master select counts as high for the burst logic.
    wire strobes_hi  = (bus.processor_addr_strobe_n || bus.master_select_n)
                       && bus.controller_addr_strobe_n;                 // R2 R23
    wire advance     = active_reg && strobes_hi && !bus.burst_advance_n; // R5 R23

    // Write decode; the processor strobe edge ignores the lane inputs.
    wire lane_ok     = !(load && processor_addr_strobe_n_eff);                              // R22
    wire [1:0] lanes_sel = bus.all_bytes_write_n
                           ? (bus.byte_write_gate_n ? pbsp_pkg::LANES_NONE
                                                    : ~bus.lane_write_n)  // R7 R8
                           : pbsp_pkg::LANES_ALL;                         // R6
    wire [1:0] lanes = (lane_ok && (active_reg || load)) ? lanes_sel : pbsp_pkg::LANES_NONE;
    wire is_write    = lanes != pbsp_pkg::LANES_NONE;
    wire hold_beat   = active_reg && strobes_hi && bus.burst_advance_n;
    wire access      = load || advance || (hold_beat && !processor_addr_strobe_n_cycle_reg);
    wire [1:0] acc_bits = burst_bits(order_il_reg, start_reg, beat_next);
    wire [pbsp_pkg::ADDR_W-1:0] acc_addr = load ? bus.addr
                                : {addr_reg[pbsp_pkg::ADDR_W-1:2], acc_bits}; // R25
    wire do_read     = live && (load || advance || hold_beat) && !is_write;
    // A deselect cycle must never push a write, even with the write enables low.
    wire do_write    = live && (load || (active_reg && strobes_hi)) && is_write; // R7

    always_comb begin
        addr_next   = addr_reg;
        beat_next   = beat_reg;
        active_next = active_reg;
        if (load) begin
            addr_next   = bus.addr;                                     // R1
            beat_next   = '0;
            active_next = 1'b1;
        end else if (deselect) begin
            active_next = 1'b0;                                         // R4
        end else if (advance) begin
            beat_next   = beat_reg + pbsp_pkg::BEAT_ONE;                // R5 R23
        end
    end

    assign wq_in.addr  = acc_addr;
    assign wq_in.lanes = lanes;
    assign wq_in.wdata = bus.wdata;

    pbsp_fifo #(
        .WIDTH ($bits(pbsp_pkg::pbsp_wr_t)),
        .DEPTH (pbsp_pkg::FIFO_DEPTH)
    ) u_wq (
        .clock     (clock),
        .reset     (reset),
        .clk_en    (clk_en),
        .in_valid  (do_write),
        .in_ready  (wq_in_ready),
        .in_data   (wq_in),
        .out_valid (wq_out_valid),
        .out_ready (!do_read),
        .out_data  (wq_out)
    );
    // The array has one port: reads take it first, so writes drain in idle cycles.
    wire wq_pop = wq_out_valid && !do_read && clk_en;

    always_ff @(posedge clock) begin
        if (wq_pop && wq_out.lanes[0]) begin
            mem_reg[wq_out.addr][pbsp_pkg::LANE_W-1:0] <= wq_out.wdata[pbsp_pkg::LANE_W-1:0];
        end
        if (wq_pop && wq_out.lanes[1]) begin
            mem_reg[wq_out.addr][pbsp_pkg::DATA_W-1:pbsp_pkg::LANE_W] <=
                wq_out.wdata[pbsp_pkg::DATA_W-1:pbsp_pkg::LANE_W];
        end
        if (do_read) begin
            rdata_reg <= mem_reg[acc_addr];                              // R21
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            sleep_sync_reg <= 3'h0;
            sleep_reg      <= 1'b0;                                     // R20
            order_sync_reg <= 3'h7;
            order_il_reg   <= 1'b1;                                     // R11
        end else if (clk_en) begin
            sleep_sync_reg <= {sleep_sync_reg[1:0], sleep_pin};
            if (sleep_sync_reg[2] == sleep_sync_reg[1]) begin
                sleep_reg <= sleep_sync_reg[2];                         // R14 R15
            end
            order_sync_reg <= {order_sync_reg[1:0], burst_order_sel};
            if (order_sync_reg[2] == order_sync_reg[1]) begin
                order_il_reg <= order_sync_reg[2];                      // R11
            end
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            addr_reg       <= '0;
            start_reg      <= 2'h0;
            beat_reg       <= 2'h0;
            active_reg     <= 1'b0;
            processor_addr_strobe_n_cycle_reg <= 1'b0;
            read_pend_reg  <= 1'b0;
        end else if (clk_en && sleep_now) begin
            active_reg    <= 1'b0;                                      // R14 R16
            read_pend_reg <= 1'b0;
        end else if (live) begin
            addr_reg       <= addr_next;
            start_reg      <= load ? bus.addr[1:0] : start_reg;
            beat_reg       <= beat_next;
            active_reg     <= active_next;
            processor_addr_strobe_n_cycle_reg <= load && processor_addr_strobe_n_eff;
            read_pend_reg  <= do_read;
        end
    end

    // Data leaves one edge after the array read; deselect, sleep or a write clears its valid flag.
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            read_valid_reg <= 1'b0;
            data_out_reg   <= '0;
        end else if (clk_en) begin
            read_valid_reg <= read_pend_reg && !sleep_now && !deselect && !do_write; // R9 R26
            data_out_reg   <= rdata_reg;                                // R21
        end
    end

    // The enable is resampled every clock; a true async path is not allowed at a flop output.
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            oe_n_reg  <= 1'b1;
            stall_reg <= 1'b0;
        end else begin
            oe_n_reg  <= !(read_valid_reg && !output_enable_n && !sleep_now); // R9 R10 R16
            stall_reg <= !wq_in_ready;
        end
    end

    assign data_out    = data_out_reg;
    assign data_oe_n   = oe_n_reg;
    assign write_stall = stall_reg;
    assign asleep      = sleep_reg;
endmodule

// ===== pbsp_pkg.sv
// Package with the constants and carrier types of the pipelined burst memory port.
// Operation
// R1: Address is captured only with all chip enables active and a strobe asserted.
// R2: Master select inactive blocks the processor strobe; controller strobe still acts.
// R3: Secondary selects are active high and low, sampled on a qualifying strobe.
// R4: A strobe low loads a new address, or deselects when selects are inactive.
// R5: Burst advance low continues the ongoing burst with the next address.
// R6: All-bytes write low writes all 18 bits, ignoring gate and lane inputs.
// R7: With gate low, any lane low means write, all lanes high mean read.
// R8: Gate high reads; gate low writes exactly the lanes that are low.
// R9: Data pins are driven only while selected, reading and output enabled.
// R10: Output enable switches the drivers without waiting for a clock edge; the core registers it, so it acts one clock edge later.
// R11: Burst order select high or open is interleaved, low is linear.
// R12: Interleaved order gives the start value XOR the beat count.
// R13: Linear order increments the two low bits by one, wrapping modulo four.
// R14: Sleep pin high puts the memory into sleep, deselected, contents kept.
// R15: Sleep lasts exactly while the sleep pin stays high, with no timeout.
// R16: In sleep all inputs but the sleep pin are ignored, data pins released.
// R17: The master completes every pending operation before raising the sleep pin.
// R18: During wake-up the master issues only deselect or read cycles.
// R19: The master disables output drivers before a write that follows a read.
// R20: The sleep pin is pulled down, so an open pin means normal operation.
// R21: Read data appears one clock edge after the address is registered; the core updates data_out then but drops data_oe_n one edge later.
// R22: The edge sampling the processor strobe ignores advance and lane writes.
// R23: The burst address advances only on advance low with both strobes high.
// R24: A controller-strobe cycle needs processor strobe high and samples write enables.
// R25: The burst counter covers only the two lowest address bits.
// R26: After a registered deselect the data pins float within one clock cycle.
package pbsp_pkg;
    localparam int ADDR_W     = 18;
    localparam int DATA_W     = 18;
    localparam int LANE_W     = 9;
    localparam int LANES      = 2;
    localparam int DEPTH      = 262144;
    localparam int FIFO_DEPTH = 4;
    localparam logic [1:0] BEAT_ONE   = 2'h1;
    localparam logic [1:0] LANES_NONE = 2'h0;
    localparam logic [1:0] LANES_ALL  = 2'h3;

    typedef struct packed {
        logic                  master_select_n;
        logic                  chip_select_hi;
        logic                  chip_select_lo_n;
        logic                  processor_addr_strobe_n;
        logic                  controller_addr_strobe_n;
        logic                  burst_advance_n;
        logic                  all_bytes_write_n;
        logic                  byte_write_gate_n;
        logic [LANES-1:0]      lane_write_n;
        logic [ADDR_W-1:0]     addr;
        logic [DATA_W-1:0]     wdata;
    } pbsp_bus_t;

    typedef struct packed {
        logic [ADDR_W-1:0]     addr;
        logic [LANES-1:0]      lanes;
        logic [DATA_W-1:0]     wdata;
    } pbsp_wr_t;
endpackage

// ===== pbsp_fifo.sv
// Small synchronous FIFO with valid and ready on both sides.
`timescale 1ns/100ps
module pbsp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    // Clocking
    input  wire logic             clock,
    input  wire logic             reset,
    input  wire logic             clk_en,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int PW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [PW-1:0]    wr_ptr_reg;
    logic [PW-1:0]    rd_ptr_reg;
    logic [PW:0]      count_reg;
    wire              push = in_valid && in_ready;
    wire              pop  = out_valid && out_ready;

    assign in_ready  = count_reg != (PW+1)'(DEPTH);
    assign out_valid = count_reg != '0;
    assign out_data  = mem_reg[rd_ptr_reg];

    always_ff @(posedge clock) begin
        if (clk_en && push) begin
            mem_reg[wr_ptr_reg] <= in_data;
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end else if (clk_en) begin
            if (push) begin
                wr_ptr_reg <= (wr_ptr_reg == PW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= (rd_ptr_reg == PW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
            end
            count_reg <= count_reg + (PW+1)'(push) - (PW+1)'(pop);
        end
    end
endmodule

// ===== pbsp_core_props.sv
// Concurrent checks on the ports of the pipelined burst memory port.
`timescale 1ns/100ps
module pbsp_core_props (
    // Clocking
    input wire logic                        clock,
    input wire logic                        reset,
    input wire logic                        clk_en,
    // Inputs
    input wire pbsp_pkg::pbsp_bus_t         bus,
    input wire logic                        output_enable_n,
    input wire logic                        burst_order_sel,
    input wire logic                        sleep_pin,
    // Outputs
    input wire logic [pbsp_pkg::DATA_W-1:0] data_out,
    input wire logic                        data_oe_n,
    input wire logic                        write_stall,
    input wire logic                        asleep
);
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    wire desel_cmd = clk_en && !asleep && !bus.controller_addr_strobe_n && !bus.chip_select_hi;

    sleep_hiz_a: assert property (asleep |-> data_oe_n)
        else $error("Data pins driven while asleep.");
    oe_gate_a: assert property (output_enable_n |=> data_oe_n)
        else $error("Data pins driven with output enable off.");
    sleep_enter_a: assert property ((sleep_pin && clk_en) [*6] |-> asleep)
        else $error("Sleep pin held high but not asleep.");
    sleep_exit_a: assert property ((!sleep_pin && clk_en) [*6] |-> !asleep)
        else $error("Still asleep after the sleep pin fell.");
    desel_float_a: assert property (desel_cmd |-> ##[1:3] data_oe_n)
        else $error("Data pins not released after a deselect.");
    reset_quiet_a: assert property ($fell(reset) |-> data_oe_n && !asleep && !write_stall)
        else $error("Outputs not quiet after reset.");
    freeze_hold_a: assert property (!clk_en |=> $stable(data_out))
        else $error("Read data moved while clock enable was low.");
    sleep_cause_a: assert property ($rose(asleep) |-> $past(sleep_pin))
        else $error("Sleep entered without the sleep pin.");
endmodule

bind pbsp_core pbsp_core_props chk_u (
    .clock(clock), .reset(reset), .clk_en(clk_en), .bus(bus),
    .output_enable_n(output_enable_n), .burst_order_sel(burst_order_sel),
    .sleep_pin(sleep_pin), .data_out(data_out), .data_oe_n(data_oe_n),
    .write_stall(write_stall), .asleep(asleep));

// ===== pbsp_master_model.sv
// Bus master model that issues one synchronous cycle at a time.
`timescale 1ns/100ps
module pbsp_master_model (
    // Clocking
    input  wire logic           clock,
    // Bus towards the memory
    output pbsp_pkg::pbsp_bus_t bus,
    output logic                output_enable_n
);
    logic [17:0] last;

    initial begin
        bus = '1;
        output_enable_n = 1'h1;
        last = 18'h00000;
    end

    // Changes land after a falling edge and hold through the next rising edge.
    task automatic cyc(input logic [2:0] ctl, input logic [3:0] wen, input logic [1:0] sel,
                       input logic [17:0] a, input logic [17:0] d, input logic oe);
        @(negedge clock);
        // Select code: 0 and 2 deselect by either secondary select, 1 selects, 3 blocks by master.
        bus.master_select_n  = (sel == 2'h3);
        bus.chip_select_hi   = (sel != 2'h0);
        bus.chip_select_lo_n = (sel == 2'h2);
        {bus.processor_addr_strobe_n, bus.controller_addr_strobe_n, bus.burst_advance_n} = ctl;
        {bus.all_bytes_write_n, bus.byte_write_gate_n, bus.lane_write_n} = wen;
        bus.addr = a;
        // A released data bus flips every cycle so a stale value can never pass as data.
        bus.wdata = (wen == 4'hF) ? ~last : d;
        last = bus.wdata;
        output_enable_n = (wen == 4'hF) ? oe : 1'h1;
    endtask
endmodule

// ===== tb_top.sv
// Self-checking bench for the pipelined burst memory port.
`timescale 1ns/100ps
module tb_top;
    logic                        clock;
    logic                        reset;
    logic                        clk_en;
    logic                        burst_order_sel;
    logic                        sleep_pin;
    pbsp_pkg::pbsp_bus_t         bus;
    logic                        output_enable_n;
    logic [pbsp_pkg::DATA_W-1:0] data_out;
    logic                        data_oe_n;
    logic                        write_stall;
    logic                        asleep;
    int                          err_total;
    int                          tests_run;
    logic [17:0]                 mem_exp;
    logic [17:0]                 d;
    logic [17:0]                 base;
    logic [1:0]                  mask;
    logic [3:0]                  wen_tab [0:6] = '{4'h0, 4'h7, 4'hA, 4'h9, 4'h8, 4'hB, 4'hC};

    pbsp_core dut_u (.clock(clock), .reset(reset), .clk_en(clk_en), .bus(bus),
        .output_enable_n(output_enable_n), .burst_order_sel(burst_order_sel),
        .sleep_pin(sleep_pin), .data_out(data_out), .data_oe_n(data_oe_n),
        .write_stall(write_stall), .asleep(asleep));
    pbsp_master_model m_u (.clock(clock), .bus(bus), .output_enable_n(output_enable_n));

    initial begin
        clock = 1'h0;
        forever #4 clock = ~clock;
    end

    task automatic close_out();
        if (err_total == 0 && tests_run > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    task automatic check(input logic [17:0] got, input logic [17:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic desel(input int n);
        repeat (n) m_u.cyc(3'h5, 4'hF, 2'h0, 18'h00000, 18'h00000, 1'h1);
    endtask

    task automatic wr(input logic [17:0] a, input logic [17:0] v, input logic [3:0] wen,
                      input logic [1:0] sel);
        m_u.cyc(3'h5, wen, sel, a, v, 1'h1);
    endtask

    // Loads a read, holds it until the pins drive or for eight cycles, and with oe low freezes the clock enable for three cycles.
    task automatic rd(input logic [17:0] a, input logic [17:0] exp, input logic oe);
        int i;
        m_u.cyc(3'h5, 4'hF, 2'h1, a, 18'h00000, oe);
        for (i = 0; i < 8 && data_oe_n !== 1'h0; i++) m_u.cyc(3'h7, 4'hF, 2'h1, a, 18'h0, oe);
        check({17'h0, data_oe_n}, {17'h0, oe});
        if (!oe) begin
            clk_en = 1'h0;
            repeat (3) m_u.cyc(3'h7, 4'hF, 2'h1, a, 18'h00000, oe);
            clk_en = 1'h1;
            check(data_out, exp);
        end
        desel(6);
    endtask

    initial begin
        err_total = 0;
        tests_run = 0;
        reset = 1'h1;
        clk_en = 1'h1;
        burst_order_sel = 1'h1;
        sleep_pin = 1'h0;
        repeat (6) @(posedge clock);
        @(negedge clock);
        reset = 1'h0;
        desel(2);
        mem_exp = 18'h00000;
        for (int k = 0; k < 7; k++) begin
            d = ~mem_exp;
            wr(18'h00100, d, wen_tab[k], 2'h1);
            if (!wen_tab[k][3]) mask = 2'h3;
            else mask = wen_tab[k][2] ? 2'h0 : ~wen_tab[k][1:0];
            mem_exp = {mask[1] ? d[17:9] : mem_exp[17:9], mask[0] ? d[8:0] : mem_exp[8:0]};
            desel(6);
            rd(18'h00100, mem_exp, 1'h0);
        end
        for (int m = 0; m < 2; m++) begin
            burst_order_sel = (m == 0);
            desel(6);
            base = {16'h00A5 + 16'(m), m ? 2'h2 : 2'h1};
            for (int k = 0; k < 4; k++) begin
                m_u.cyc(k ? 3'h6 : 3'h5, 4'h0, 2'h1, base, 18'h0C350 + 18'(k), 1'h1);
            end
            check({17'h0, write_stall}, 18'h00000);
            desel(6);
            // A read burst: load, three advances, two holds; data trails the address by one edge.
            for (int k = 0; k < 6; k++) begin
                m_u.cyc(k == 0 ? 3'h5 : (k < 4 ? 3'h6 : 3'h7), 4'hF, 2'h1, base, 18'h00000, 1'h0);
                if (k >= 2) check(data_out, 18'h0C350 + 18'(k - 2));
            end
            desel(6);
            for (int k = 0; k < 4; k++) begin
                mask = m ? base[1:0] + 2'(k) : base[1:0] ^ 2'(k);
                rd({base[17:2], mask}, 18'h0C350 + 18'(k), 1'h0);
            end
        end
        wr(18'h00300, 18'h1E1E1, 4'h0, 2'h1);
        desel(6);
        wr(18'h00300, 18'h00F0F, 4'h0, 2'h3);
        wr(18'h00300, 18'h00F0F, 4'h0, 2'h2);
        m_u.cyc(3'h3, 4'h8, 2'h1, 18'h00300, 18'h00F0F, 1'h1);
        desel(6);
        rd(18'h00300, 18'h1E1E1, 1'h0);
        rd(18'h00300, 18'h00000, 1'h1);
        sleep_pin = 1'h1;
        for (int i = 0; i < 10 && asleep !== 1'h1; i++) desel(1);
        wr(18'h00300, 18'h00000, 4'h0, 2'h1);
        desel(20);
        check({16'h0, asleep, data_oe_n}, 18'h00003);
        sleep_pin = 1'h0;
        for (int i = 0; i < 10 && asleep !== 1'h0; i++) desel(1);
        check({17'h0, asleep}, 18'h00000);
        rd(18'h00300, 18'h1E1E1, 1'h0);
        close_out();
    end

    initial begin
        #40000;
        err_total++;
        close_out();
    end
endmodule
